// *** src/event_trigger_logging_control.sv ***
// Trigger slots, gating, qualifying delay and one-second logging control.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "trig_map.svh"

module event_trigger_logging_control
  import trig_pkg::*;
#(
  parameter int NUM_SLOTS = `NUM_SLOTS,
  parameter int HIST_DEPTH = `HIST_DEPTH,
  parameter int TICK_CYCLES = `SEC_TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire meas_t meas,
  output event_out_t event_out,
  output logic log_second,
  output meas_t hist_out,
  output logic irq
);
  localparam int AW = $clog2(HIST_DEPTH);
  localparam int CW = $bits(slot_cfg_t);
  localparam int HW = $bits(meas_t) - 1;

  if (NUM_SLOTS < 2 || NUM_SLOTS > 32) begin : g_bad_slots
    $error("NUM_SLOTS must lie between 2 and 32");
  end
  if (HIST_DEPTH < 2 || (1 << AW) != HIST_DEPTH) begin : g_bad_depth
    $error("HIST_DEPTH must be a power of two");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  function automatic logic cmp_hit(cmp_fn_t fn, logic signed [31:0] x,
                                   logic signed [31:0] lim,
                                   logic signed [31:0] rv);
    logic signed [32:0] xs;
    logic signed [32:0] ls;
    logic signed [32:0] d;
    logic signed [32:0] ax;
    logic signed [32:0] ad;
    xs = {x[31], x};
    ls = {lim[31], lim};
    d = xs - {rv[31], rv};
    ax = xs[32] ? -xs : xs;
    ad = d[32] ? -d : d;
    case (fn)
      FN_GT: cmp_hit = xs > ls;
      FN_LT: cmp_hit = xs < ls;
      FN_ABS_GT: cmp_hit = ax > ls;
      FN_DEV_GT: cmp_hit = ad > ls;
      default: cmp_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [4:0] first_set(logic [NUM_SLOTS-1:0] v);
    first_set = 5'h00;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = 5'(k);
      end
    end
  endfunction

  // Software edits the shadow copy; the slots run from the live copy.
  slot_set_t shadow [NUM_SLOTS];
  slot_set_t live [NUM_SLOTS];
  logic [31:0] slot_state [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] active;
  logic [NUM_SLOTS-1:0] fire;
  logic [NUM_SLOTS-1:0] clr;
  logic [NUM_SLOTS-1:0] rec_en;
  logic [NUM_SLOTS-1:0] logging;
  logic [NUM_SLOTS-1:0] free_slots;
  logic [NUM_SLOTS-1:0] evt_pend;
  logic [NUM_SLOTS-1:0] served;
  logic [4:0] sel;
  logic [31:0] tick_cnt;
  logic tick;
  logic is_global;
  logic [4:0] wslot;
  logic [2:0] wfield;
  slot_cfg_t new_cfg;
  logic wr_cfg;
  logic refuse;
  logic do_commit;
  logic do_discard;
  logic [`INT_W-1:0] int_status;
  logic [`INT_W-1:0] int_mask;
  logic [`INT_W-1:0] int_set;
  logic [31:0] next_rdata;

  assign is_global = addr[`GLOBAL_BIT];
  assign wslot = addr[`SLOT_MSB:`SLOT_LSB];
  assign wfield = addr[`SLOT_LSB-1:0];
  assign new_cfg = slot_cfg_t'(wdata[CW-1:0]);
  assign wr_cfg = wr && !is_global && wfield == `SR_CFG &&
                  32'(wslot) < NUM_SLOTS;
  // A taken slot cannot be handed to the other kind without a switch off.
  assign refuse = wr_cfg && (new_cfg.kind == 2'h3 ||
                  (new_cfg.kind != SLOT_OFF &&
                   shadow[wslot].cfg.kind != SLOT_OFF &&
                   new_cfg.kind != shadow[wslot].cfg.kind));
  assign do_commit = wr && is_global && addr[7:0] == `GR_CTRL &&
                     wdata[`CTRL_COMMIT];
  assign do_discard = wr && is_global && addr[7:0] == `GR_CTRL &&
                      wdata[`CTRL_DISCARD] && !do_commit;

  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 32'h0;
    end else if (tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
        shadow[k] <= '0;
      end
    end else if (do_discard) begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
        shadow[k] <= live[k];
      end
    end else if (wr && !is_global && 32'(wslot) < NUM_SLOTS) begin
      case (wfield)
        `SR_CFG: begin
          if (!refuse) begin
            shadow[wslot].cfg <= new_cfg;
          end
        end
        `SR_LIMIT: shadow[wslot].limit <= wdata;
        `SR_REF: shadow[wslot].ref_value <= wdata;
        `SR_QUAL: shadow[wslot].qualify_delay <= wdata[15:0];
        `SR_LOGTIME: shadow[wslot].log_time <= log_time_t'(wdata);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
        live[k] <= '0;
      end
    end else if (do_commit) begin
      for (int k = 0; k < NUM_SLOTS; k++) begin
        live[k] <= shadow[k];
      end
    end
  end

  for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
    slot_set_t s;
    logic [4:0] midx;
    logic m_act;
    logic match;
    logic allowed;
    logic qual_met;
    logic user;
    logic act;
    logic cnd;
    logic arm;
    logic mprev;
    logic [15:0] qcnt;
    logic [15:0] lcnt;
    logic [15:0] pcnt;

    assign s = live[i];
    assign user = s.cfg.kind == SLOT_USER;
    assign midx = s.cfg.master - 5'h01;
    assign m_act = 32'(midx) < NUM_SLOTS ? active[midx] : 1'b0;
    assign match = meas.valid && user && meas.source == s.cfg.source &&
                   meas.phase == s.cfg.phase;
    assign qual_met = s.qualify_delay == 16'h0 ||
                      qcnt >= s.qualify_delay;
    assign fire[i] = user && !act && cnd && allowed && qual_met;
    assign clr[i] = act && (!cnd || !user);
    assign active[i] = act;
    assign rec_en[i] = s.cfg.event_record_enable;
    assign free_slots[i] = shadow[i].cfg.kind == SLOT_OFF;
    assign logging[i] = tick && (lcnt != 16'h0 || pcnt != 16'h0);
    assign slot_state[i] = {act, cnd, arm, 13'h0, qcnt};

    always_comb begin
      case (s.cfg.gate)
        GATE_OFF: allowed = 1'b1;
        GATE_ON_MASTER_SET: allowed = m_act;
        GATE_ON_MASTER_CLEAR: allowed = arm;
        default: allowed = 1'b0;
      endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        cnd <= 1'b0;
      end else if (!user) begin
        cnd <= 1'b0;
      end else if (match) begin
        cnd <= cmp_hit(s.cfg.fn, meas.value, s.limit, s.ref_value);
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        qcnt <= 16'h0;
      end else if (!cnd || !allowed || act) begin
        qcnt <= 16'h0;
      end else if (tick && !qual_met) begin
        qcnt <= qcnt + 16'h1;
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        act <= 1'b0;
      end else if (fire[i]) begin
        act <= 1'b1;
      end else if (clr[i]) begin
        act <= 1'b0;
      end
    end

    // The arm waits for a falling edge of the master and is spent by firing.
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        mprev <= 1'b0;
        arm <= 1'b0;
      end else begin
        mprev <= m_act;
        if (fire[i] || s.cfg.gate != GATE_ON_MASTER_CLEAR) begin
          arm <= 1'b0;
        end else if (mprev && !m_act) begin
          arm <= 1'b1;
        end
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        lcnt <= 16'h0;
        pcnt <= 16'h0;
      end else if (fire[i]) begin
        lcnt <= s.log_time.active_log_seconds;
        pcnt <= 16'h0;
      end else if (clr[i]) begin
        lcnt <= 16'h0;
        pcnt <= s.log_time.post_clear_log_seconds;
      end else if (tick) begin
        if (lcnt != 16'h0) begin
          lcnt <= lcnt - 16'h1;
        end
        if (pcnt != 16'h0) begin
          pcnt <= pcnt - 16'h1;
        end
      end
    end
  end

  // Records wait in a pending set so simultaneous firings are not lost.
  assign sel = first_set(evt_pend);
  assign served = |evt_pend ?
                  NUM_SLOTS'({{(NUM_SLOTS-1){1'b0}}, 1'b1} << sel) : '0;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      evt_pend <= '0;
      event_out <= '0;
    end else begin
      evt_pend <= (evt_pend & ~served) | (fire & rec_en);
      event_out.record <= |evt_pend;
      event_out.slot <= sel;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      log_second <= 1'b0;
    end else begin
      log_second <= |logging;
    end
  end

  // History of recent samples, dumped oldest first when a record fires.
  dump_state_t dump_state;
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] dcnt;
  logic rd_pend;
  logic hist_wr;
  logic hist_rd;
  logic [HW-1:0] hist_q;

  assign hist_wr = meas.valid && dump_state == DUMP_IDLE;
  assign hist_rd = dump_state == DUMP_RUN;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dump_state <= DUMP_IDLE;
      wptr <= '0;
      rptr <= '0;
      dcnt <= '0;
    end else begin
      case (dump_state)
        DUMP_IDLE: begin
          if (hist_wr) begin
            wptr <= wptr + 1'b1;
          end
          if (|(fire & rec_en)) begin
            rptr <= hist_wr ? wptr + 1'b1 : wptr;
            dcnt <= (AW+1)'(HIST_DEPTH);
            dump_state <= DUMP_RUN;
          end
        end
        DUMP_RUN: begin
          rptr <= rptr + 1'b1;
          dcnt <= dcnt - 1'b1;
          if (dcnt == (AW+1)'(1)) begin
            dump_state <= DUMP_IDLE;
          end
        end
        default: dump_state <= DUMP_IDLE;
      endcase
    end
  end

  history_mem #(.WIDTH(HW), .DEPTH(HIST_DEPTH)) u_hist (
    .ref_clk(ref_clk),
    .wr_en(hist_wr),
    .wr_addr(wptr),
    .wr_data({meas.source, meas.phase, meas.value}),
    .rd_en(hist_rd),
    .rd_addr(rptr),
    .rd_data(hist_q)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_pend <= 1'b0;
      hist_out <= '0;
    end else begin
      rd_pend <= hist_rd;
      hist_out <= meas_t'({rd_pend, hist_q});
    end
  end

  assign int_set[`INT_FIRED] = |fire;
  assign int_set[`INT_CLEARED] = |clr;
  assign int_set[`INT_REFUSED] = refuse;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= `RST_INT_STATUS;
      int_mask <= `RST_INT_MASK;
      irq <= 1'b0;
    end else begin
      if (wr && is_global && addr[7:0] == `GR_INT_STATUS) begin
        int_status <= (int_status & ~wdata[`INT_W-1:0]) | int_set;
      end else begin
        int_status <= int_status | int_set;
      end
      if (wr && is_global && addr[7:0] == `GR_INT_MASK) begin
        int_mask <= wdata[`INT_W-1:0];
      end
      irq <= |(int_status & int_mask);
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    if (is_global) begin
      case (addr[7:0])
        `GR_INT_STATUS: next_rdata = 32'(int_status);
        `GR_INT_MASK: next_rdata = 32'(int_mask);
        `GR_ACTIVE: next_rdata = 32'(active);
        `GR_FREE: next_rdata = 32'(free_slots);
        default: next_rdata = 32'h0;
      endcase
    end else if (32'(wslot) < NUM_SLOTS) begin
      case (wfield)
        `SR_CFG: next_rdata = 32'(shadow[wslot].cfg);
        `SR_LIMIT: next_rdata = shadow[wslot].limit;
        `SR_REF: next_rdata = shadow[wslot].ref_value;
        `SR_QUAL: next_rdata = 32'(shadow[wslot].qualify_delay);
        `SR_LOGTIME: next_rdata = shadow[wslot].log_time;
        `SR_STATE: next_rdata = slot_state[wslot];
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      rdata <= next_rdata;
    end
  end
endmodule

// *** src/history_mem.sv ***
// Circular sample memory with a registered read port.
`timescale 1ns/100ps
module history_mem #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("DEPTH must be at least 2 and WIDTH at least 1");
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// *** src/trig_map.svh ***
// Register offsets, field positions, reset values and timing figures.
`ifndef TRIG_MAP_SVH
`define TRIG_MAP_SVH
`define CLK_PERIOD_NS 100
`define SEC_TICK_NS 1000000000
`define NUM_SLOTS 32
`define HIST_DEPTH 64
`define ADDR_W 9
`define GLOBAL_BIT 8
`define SLOT_MSB 7
`define SLOT_LSB 3
`define SR_CFG 3'h0
`define SR_LIMIT 3'h1
`define SR_REF 3'h2
`define SR_QUAL 3'h3
`define SR_LOGTIME 3'h4
`define SR_STATE 3'h5
`define GR_CTRL 8'h00
`define GR_INT_STATUS 8'h01
`define GR_INT_MASK 8'h02
`define GR_ACTIVE 8'h03
`define GR_FREE 8'h04
`define CTRL_COMMIT 0
`define CTRL_DISCARD 1
`define INT_FIRED 0
`define INT_CLEARED 1
`define INT_REFUSED 2
`define INT_W 3
`define RST_INT_MASK 3'h0
`define RST_INT_STATUS 3'h0
`endif

// *** src/trig_pkg.sv ***
// Types shared by the trigger and logging control block.
package trig_pkg;
  typedef enum logic [1:0] {
    SLOT_OFF = 2'h0, SLOT_USER = 2'h1, SLOT_PQ = 2'h2
  } slot_kind_t;
  typedef enum logic [1:0] {
    FN_GT = 2'h0, FN_LT = 2'h1, FN_ABS_GT = 2'h2, FN_DEV_GT = 2'h3
  } cmp_fn_t;
  typedef enum logic [1:0] {
    PH_A = 2'h0, PH_B = 2'h1, PH_C = 2'h2, PH_AVG = 2'h3
  } phase_t;
  typedef enum logic [1:0] {
    GATE_OFF = 2'h0, GATE_ON_MASTER_SET = 2'h1, GATE_ON_MASTER_CLEAR = 2'h2
  } gate_t;
  typedef enum logic {DUMP_IDLE = 1'b0, DUMP_RUN = 1'b1} dump_state_t;
  typedef struct packed {
    logic event_record_enable;
    logic [4:0] master;
    gate_t gate;
    phase_t phase;
    logic [4:0] source;
    cmp_fn_t fn;
    slot_kind_t kind;
  } slot_cfg_t;
  typedef struct packed {
    logic [15:0] post_clear_log_seconds;
    logic [15:0] active_log_seconds;
  } log_time_t;
  typedef struct packed {
    slot_cfg_t cfg;
    logic signed [31:0] limit;
    logic signed [31:0] ref_value;
    logic [15:0] qualify_delay;
    log_time_t log_time;
  } slot_set_t;
  typedef struct packed {
    logic valid;
    logic [4:0] source;
    phase_t phase;
    logic signed [31:0] value;
  } meas_t;
  typedef struct packed {
    logic record;
    logic [4:0] slot;
  } event_out_t;
endpackage

// *** tb/event_trigger_logging_control_bench.sv ***
// Self-checking bench for the trigger and logging control block.
`timescale 1ns/100ps
`include "trig_map.svh"
module event_trigger_logging_control_bench
  import trig_pkg::*;
;
  localparam int TK = 20;
  logic ref_clk, nrst, wr, rd, log_second, irq;
  logic [8:0] addr;
  logic [31:0] wdata, rdata, rv;
  meas_t meas, hist_out;
  meas_t last_hist;
  event_out_t event_out;
  int mismatches, num_checks, n_log;
  int n_rec [32];
  event_trigger_logging_control #(.HIST_DEPTH(8), .TICK_CYCLES(TK)) i_dut (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .meas(meas), .event_out(event_out),
    .log_second(log_second), .hist_out(hist_out), .irq(irq));
  meas_source i_meas (.ref_clk(ref_clk), .meas(meas));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (event_out.record === 1'b1) begin
      n_rec[event_out.slot]++;
    end
    if (log_second === 1'b1) begin
      n_log++;
    end
    if (hist_out.valid === 1'b1) begin
      last_hist = hist_out;
    end
  end
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic wreg(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [8:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  function automatic logic [8:0] sa(input int s, input logic [2:0] f);
    return {1'b0, s[4:0], f};
  endfunction
  function automatic slot_cfg_t mk(slot_kind_t k, cmp_fn_t f, phase_t p,
      logic [4:0] src, gate_t g, logic [4:0] m, logic e);
    return '{e, m, g, p, src, f, k};
  endfunction
  task automatic setup(input int s, input slot_cfg_t c, input int lim,
                       input int q, input logic [31:0] lt);
    wreg(sa(s, `SR_CFG), {13'h0, c});
    wreg(sa(s, `SR_LIMIT), lim);
    wreg(sa(s, `SR_REF), 32'd1000);
    wreg(sa(s, `SR_QUAL), q);
    wreg(sa(s, `SR_LOGTIME), lt);
    wreg({1'b1, `GR_CTRL}, 32'h1);
  endtask
  task automatic hit(input int src, input phase_t p, input int v);
    i_meas.send(src[4:0], p, v);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic act(input logic [31:0] e);
    rreg({1'b1, `GR_ACTIVE});
    check("active", e, rv);
  endtask
  task automatic t_assign;
    slot_cfg_t c;
    c = mk(SLOT_USER, FN_GT, PH_A, 5'h1, GATE_OFF, 5'h0, 1'b0);
    rreg({1'b1, `GR_INT_MASK});
    check("mask", 32'h0, rv);
    rreg({1'b1, 8'h20});
    check("unmapped", 32'h0, rv);
    rreg({1'b1, `GR_FREE});
    check("free", 32'hffffffff, rv);
    wreg(sa(3, `SR_CFG), {13'h0, c});
    rreg({1'b1, `GR_FREE});
    check("free", 32'hfffffff7, rv);
    wreg(sa(3, `SR_CFG), 32'h2);
    rreg(sa(3, `SR_CFG));
    check("cfg", {13'h0, c}, rv);
    rreg({1'b1, `GR_INT_STATUS});
    check("status", 32'h4, rv);
    wreg(sa(3, `SR_CFG), 32'h0);
    rreg({1'b1, `GR_FREE});
    check("free", 32'hffffffff, rv);
    wreg({1'b1, `GR_INT_STATUS}, 32'h7);
  endtask
  task automatic t_commit;
    wreg(sa(5, `SR_CFG), 32'h61);
    hit(6, PH_A, 5);
    act(32'h0);
    wreg({1'b1, `GR_CTRL}, 32'h1);
    hit(6, PH_A, 5);
    act(32'h20);
    hit(6, PH_A, 0);
    wreg(sa(5, `SR_LIMIT), 32'h22);
    rreg(sa(5, `SR_LIMIT));
    check("limit", 32'h22, rv);
    wreg({1'b1, `GR_CTRL}, 32'h2);
    rreg(sa(5, `SR_LIMIT));
    check("limit", 32'h0, rv);
    wreg(sa(5, `SR_LIMIT), 32'h33);
    wreg({1'b1, `GR_CTRL}, 32'h3);
    rreg(sa(5, `SR_LIMIT));
    check("limit", 32'h33, rv);
  endtask
  task automatic t_compare;
    int hi [4] = '{101, 99, -101, 1101};
    int lo [4] = '{100, 100, -100, 1050};
    for (int i = 0; i < 4; i++) begin
      setup(0, mk(SLOT_USER, cmp_fn_t'(i), phase_t'(i), 5'h2, GATE_OFF,
        5'h0, 1'b1), 100, 0, 32'h0);
      hit(3, phase_t'(i), hi[i]);
      hit(2, phase_t'((i + 1) % 4), hi[i]);
      act(32'h0);
      hit(2, phase_t'(i), hi[i]);
      act(32'h1);
      hit(2, phase_t'(i), lo[i]);
      act(32'h0);
      // The newest sample of the history dump is the triggering update.
      check("history", hi[i], last_hist.value);
    end
    check("records", 32'd4, n_rec[0]);
  endtask
  task automatic t_delay;
    setup(1, mk(SLOT_USER, FN_GT, PH_B, 5'h7, GATE_OFF, 5'h0, 1'b0), 0, 2,
      32'h0);
    hit(7, PH_B, 5);
    act(32'h0);
    rreg(sa(1, `SR_STATE));
    check("state", 32'h1, rv[31:30]);
    repeat (3 * TK) @(posedge ref_clk);
    act(32'h2);
    hit(7, PH_B, 0);
  endtask
  task automatic t_gate;
    setup(10, mk(SLOT_USER, FN_GT, PH_A, 5'h8, GATE_OFF, 5'h0, 1'b0), 0, 0,
      32'h0);
    setup(11, mk(SLOT_USER, FN_GT, PH_A, 5'h9, GATE_ON_MASTER_SET, 5'd11,
      1'b0), 0, 0, 32'h0);
    setup(12, mk(SLOT_USER, FN_GT, PH_A, 5'ha, GATE_ON_MASTER_CLEAR,
      5'd11, 1'b0), 0, 0, 32'h0);
    hit(9, PH_A, 5);
    hit(10, PH_A, 5);
    act(32'h0);
    hit(8, PH_A, 5);
    hit(9, PH_A, 5);
    act(32'hc00);
    hit(8, PH_A, 0);
    hit(9, PH_A, 0);
    hit(10, PH_A, 5);
    act(32'h1000);
    hit(10, PH_A, 0);
  endtask
  task automatic t_log;
    int base;
    wreg({1'b1, `GR_INT_STATUS}, 32'h7);
    wreg({1'b1, `GR_INT_MASK}, 32'h1);
    setup(13, mk(SLOT_USER, FN_GT, PH_C, 5'hb, GATE_OFF, 5'h0, 1'b0), 0, 0,
      {16'd1, 16'd2});
    base = n_log;
    hit(11, PH_C, 5);
    check("irq", 32'h1, irq);
    repeat (4 * TK) @(posedge ref_clk);
    check("logs", 32'd2, n_log - base);
    check("records", 32'd0, n_rec[13]);
    wreg({1'b1, `GR_INT_MASK}, 32'h0);
    @(posedge ref_clk);
    #1 check("irq", 32'h0, irq);
    hit(11, PH_C, 0);
    repeat (3 * TK) @(posedge ref_clk);
    check("logs", 32'd3, n_log - base);
    rreg({1'b1, `GR_INT_STATUS});
    check("status", 32'h3, rv);
    wreg({1'b1, `GR_INT_STATUS}, 32'h7);
    wreg({1'b1, `GR_INT_MASK}, 32'h3);
    repeat (2) @(posedge ref_clk);
    #1 check("irq", 32'h0, irq);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_assign();
    t_commit();
    t_compare();
    t_delay();
    t_gate();
    t_log();
    print_verdict();
  end
  initial begin
    #500000;
    mismatches++;
    print_verdict();
  end
endmodule
bind event_trigger_logging_control trig_checker #(
  .HIST_DEPTH(HIST_DEPTH)) i_chk (.ref_clk(ref_clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .meas(meas), .event_out(event_out), .log_second(log_second),
  .hist_out(hist_out), .irq(irq));

// *** tb/meas_source.sv ***
// Measurement processor model issuing one-cycle measurement updates.
`timescale 1ns/100ps
module meas_source
  import trig_pkg::*;
(
  input wire logic ref_clk,
  output meas_t meas
);
  initial begin
    meas = '0;
  end
  // Outside an update the payload is inverted, so sampling without
  // valid sees a changed value rather than a stale copy.
  task automatic send(input logic [4:0] src, input phase_t ph,
                      input logic [31:0] v);
    @(posedge ref_clk);
    meas <= '{1'b1, src, ph, v};
    @(posedge ref_clk);
    meas <= '{1'b0, ~src, phase_t'(~ph), ~v};
  endtask
endmodule

// *** tb/trig_checker.sv ***
// Port-level assertions for the trigger and logging control block.
`timescale 1ns/100ps
`include "trig_map.svh"
module trig_checker
  import trig_pkg::*;
#(
  parameter int HIST_DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire meas_t meas,
  input wire event_out_t event_out,
  input wire logic log_second,
  input wire meas_t hist_out,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  int run_len;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_len <= 0;
    end else if (hist_out.valid) begin
      run_len <= run_len + 1;
    end else begin
      run_len <= 0;
    end
  end
  sequence s_edit;
    wr && !addr[8] && addr[2:0] >= `SR_LIMIT && addr[2:0] <= `SR_LOGTIME;
  endsequence
  sequence s_off;
    wr && !addr[8] && addr[2:0] == `SR_CFG && wdata[1:0] == 2'h0;
  endsequence
  sequence s_quiet;
    !wr && !rd;
  endsequence
  a_edit_readback: assert property (
    s_edit ##1 s_quiet ##1 (rd && addr == $past(addr, 2)) |=>
    rdata == (($past(addr[2:0], 3) == `SR_QUAL) ?
      {16'h0, $past(wdata[15:0], 3)} : $past(wdata, 3)))
    else $error("edited field reads back wrong");
  a_free_on_off: assert property (
    s_off ##1 s_quiet ##1 (rd && addr == {1'b1, `GR_FREE}) |=>
    rdata[$past(addr[7:3], 3)])
    else $error("switched-off slot not free");
  a_rec_one_pulse: assert property (
    event_out.record |=>
    !event_out.record || event_out.slot != $past(event_out.slot))
    else $error("event record pulse too long");
  // Holds only while the tick divider is at least nine cycles long.
  a_log_gap: assert property (log_second |=> !log_second [*8])
    else $error("log pulses closer than a tick");
  a_hist_len: assert property ($fell(hist_out.valid) |->
    run_len == HIST_DEPTH)
    else $error("history dump length wrong");
  a_irq_masked: assert property (wr && addr == {1'b1, `GR_INT_MASK} &&
    wdata[`INT_W-1:0] == 3'h0 |-> ##2 !irq)
    else $error("interrupt high with mask clear");
  a_irq_sticky: assert property (irq && !$past(wr) |=> irq)
    else $error("interrupt dropped without a write");
  a_unmapped_zero: assert property (rd && addr[8] &&
    addr[7:0] > `GR_FREE |=> rdata == 32'h0)
    else $error("unmapped address reads nonzero");
endmodule
